/* File: hw/gpr_bank_file.sv */
// banked register file with global-bank cache of mapped registers
`timescale 1ns/1ps
`default_nettype none
module gpr_bank_file (
    input  wire logic                                     mclk,
    input  wire logic                                     rst_n,
    input  wire gpr_bank_pkg::reg_rd_t [2:0]              rd_port,
    output logic [2:0][15:0]                              rd_data,
    input  wire gpr_bank_pkg::reg_wr_t [1:0]              wr_port,
    input  wire gpr_bank_pkg::bank_event_t                bank_event,
    input  wire logic [23:0]                              context_base_pointer,
    input  wire logic                                     context_switch,
    output logic [1:0]                                    bank_select,
    output logic                                          busy,
    input  wire gpr_bank_pkg::mem_req_t                   full_req,
    output logic                                          full_hit,
    output logic                                          full_rvalid,
    output logic [15:0]                                   full_rdata,
    output logic                                          ram_rd_en,
    output logic                                          ram_wr_en,
    output logic [23:0]                                   ram_addr,
    output logic [15:0]                                   ram_wdata,
    input  wire logic [15:0]                              ram_rdata
);
    import gpr_bank_pkg::*;

    typedef struct packed {
        logic [NUM_BANKS-1:0][NUM_REGS-1:0][DATA_W-1:0] regs;
        bank_sel_t                                      bank;
        switch_state_t                                  sw;
        logic [IDX_W-1:0]                               cnt;
        logic [ADDR_W-1:0]                              tag;
        logic [ADDR_W-1:0]                              new_tag;
        logic                                           valid;
        logic                                           rd_en;
        logic                                           wr_en;
        logic [ADDR_W-1:0]                              addr;
        logic [DATA_W-1:0]                              wdata;
        logic [NUM_RD-1:0][DATA_W-1:0]                  rdat;
        logic                                           fvalid;
        logic [DATA_W-1:0]                              fdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // word address of register n in the bank at base
    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] base,
                                                     input logic [IDX_W-1:0] n);
        word_addr = base + {19'h0, n, 1'b0};
    endfunction

    // helpers shared by the sequencer and the operand ports
    logic [ADDR_W-1:0] off;
    logic              in_window;
    logic              aligned;
    logic              hit;
    logic [IDX_W-1:0]  hit_idx;
    logic [1:0]        gb;
    logic              ready;
    logic              last_word;
    bank_sel_t         bank_evt;
    logic [DATA_W-1:0] rd_sel  [NUM_RD];
    logic [DATA_W-1:0] wr_mask [NUM_WR];
    logic [DATA_W-1:0] wr_val  [NUM_WR];

    // a full address only hits while the global bank is active; with a local
    // bank active the access goes out to memory untouched
    always_comb begin
        off       = full_req.addr - state_reg.tag;
        in_window = off <= BANK_SPAN;
        aligned   = !off[0];
        ready     = state_reg.sw == SW_IDLE && state_reg.valid;
        last_word = state_reg.cnt == IDX_W'(NUM_REGS - 1);
        hit       = state_reg.valid && in_window && aligned
                    && state_reg.bank == BANK_GLOBAL;
        hit_idx   = off[4:1];
        gb        = 2'(BANK_GLOBAL);
    end

    // lanes are picked per port, so the registered answer is already aligned
    for (genvar p = 0; p < NUM_RD; p++) begin : g_rd
        logic [DATA_W-1:0] word;
        assign word      = state_reg.regs[state_reg.bank][rd_port[p].idx];
        assign rd_sel[p] = !rd_port[p].byte_op ? word :
                           rd_port[p].hi_byte ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
    end

    // a byte write leaves the other lane of the register untouched
    for (genvar p = 0; p < NUM_WR; p++) begin : g_wr
        logic [DATA_W-1:0] mask;
        logic [DATA_W-1:0] val;
        always_comb begin
            if (!wr_port[p].byte_op) begin
                mask = 16'hFFFF;
                val  = wr_port[p].data;
            end else if (wr_port[p].hi_byte) begin
                mask = 16'hFF00;
                val  = {wr_port[p].data[7:0], 8'h00};
            end else begin
                mask = 16'h00FF;
                val  = {8'h00, wr_port[p].data[7:0]};
            end
        end
        assign wr_mask[p] = mask;
        assign wr_val[p]  = val;
    end

    // priority trap, interrupt entry, interrupt return, status write; the
    // chosen bank is in force from the edge after the event
    always_comb begin
        bank_evt = state_reg.bank;
        if (bank_event.trap_entry) begin
            bank_evt = BANK_GLOBAL;
        end else if (bank_event.int_entry) begin
            bank_evt = bank_sel_t'(bank_event.int_bank);
        end else if (bank_event.int_return) begin
            bank_evt = bank_sel_t'(bank_event.return_bank);
        end else if (bank_event.status_wr) begin
            bank_evt = bank_sel_t'(bank_event.status_bank);
        end
        // the spare code falls back to the global bank
        if (2'(bank_evt) == 2'h3) begin
            bank_evt = BANK_GLOBAL;
        end
    end

    always_comb begin
        state_next        = state_reg;
        state_next.rd_en  = 1'b0;
        state_next.wr_en  = 1'b0;
        state_next.fvalid = 1'b0;
        state_next.bank   = bank_evt;

        // operand writes land in the active bank only, never while busy
        for (int p = 0; p < NUM_WR; p++) begin
            if (wr_port[p].en && ready) begin
                state_next.regs[state_reg.bank][wr_port[p].idx] =
                    (state_next.regs[state_reg.bank][wr_port[p].idx] & ~wr_mask[p])
                    | wr_val[p];
            end
        end

        // full-address write into the cached window
        if (full_req.wr_en && hit && ready) begin
            state_next.regs[gb][hit_idx] = full_req.wdata;
        end
        // cached copy replaces memory data, one cycle later
        if (full_req.rd_en && hit) begin
            state_next.fvalid = 1'b1;
            state_next.fdata  = state_reg.regs[gb][hit_idx];
        end

        for (int p = 0; p < NUM_RD; p++) begin
            state_next.rdat[p] = rd_sel[p];
        end

        // switch: sixteen saves to the old window, then per word one read
        // strobe, one cycle for the ram and one capture; busy stays high all
        // along, so a switch costs 64 cycles, which is why fast tasks
        // should use a local bank instead
        unique case (state_reg.sw)
            SW_IDLE: begin
                if (context_switch || !state_reg.valid) begin
                    state_next.new_tag = context_base_pointer;
                    state_next.cnt     = '0;
                    state_next.sw      = state_reg.valid ? SW_SAVE : SW_LOAD;
                    state_next.valid   = 1'b0;
                end
            end
            SW_SAVE: begin
                state_next.wr_en = 1'b1;
                state_next.addr  = word_addr(state_reg.tag, state_reg.cnt);
                state_next.wdata = state_reg.regs[gb][state_reg.cnt];
                state_next.cnt   = state_reg.cnt + 4'h1;
                if (last_word) begin
                    state_next.sw = SW_LOAD;
                end
            end
            SW_LOAD: begin
                state_next.rd_en = 1'b1;
                state_next.addr  = word_addr(state_reg.new_tag, state_reg.cnt);
                state_next.sw    = SW_WAIT;
            end
            SW_WAIT: begin
                // the ram answers one cycle after it sees the strobe, so the
                // first wait cycle only lets the strobe reach it
                if (!state_reg.rd_en) begin
                    state_next.regs[gb][state_reg.cnt] = ram_rdata;
                    state_next.cnt = state_reg.cnt + 4'h1;
                    if (last_word) begin
                        state_next.tag   = state_reg.new_tag;
                        state_next.valid = 1'b1;
                        state_next.sw    = SW_IDLE;
                    end else begin
                        state_next.sw = SW_LOAD;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            // cache comes up invalid and reloads itself after every reset
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        rd_data     = state_reg.rdat;
        bank_select = 2'(state_reg.bank);
        // execution stalls while the global cache is invalid
        busy        = !ready;
        full_hit    = hit && full_req.rd_en;
        full_rvalid = state_reg.fvalid;
        full_rdata  = state_reg.fdata;
        ram_rd_en   = state_reg.rd_en;
        ram_wr_en   = state_reg.wr_en;
        ram_addr    = state_reg.addr;
        ram_wdata   = state_reg.wdata;
    end
endmodule
`default_nettype wire

/* File: hw/gpr_bank_pkg.sv */
// constants and carrier types for the banked working-register file
// How it works
// - each bank has sixteen registers, read or written in one cycle.
// - a mapped bank occupies sixteen consecutive words of data RAM.
// - mapped bank base address comes from the context base pointer.
// - operands come from a cached five-port register file, never RAM directly.
// - three physically separate banks: one global, two local.
// - global bank always caches the bank at the current base pointer, only one.
// - context switch writes back global bank then loads new one, word by word.
// - local banks are not memory-mapped and ignore full-address accesses.
// - exactly one bank active, chosen by the status-word bank field.
// - bank field changes on status writes, interrupt return, interrupt, trap.
// - interrupt entry takes its bank from the interrupt controller setting.
// - hardware trap entry always selects the global bank.
// - instructions reach register operands only through the register file.
// - word register address is base plus twice number; byte adds number.
// - global bank is validated before execution resumes, then serves accesses.
// - full-address read hitting the cache returns file data one cycle later.
package gpr_bank_pkg;
    localparam int NUM_REGS   = 16;
    localparam int NUM_BANKS  = 3;
    localparam int DATA_W     = 16;
    localparam int ADDR_W     = 24;
    localparam int IDX_W      = 4;
    localparam int NUM_RD     = 3;
    localparam int NUM_WR     = 2;
    localparam logic [ADDR_W-1:0] BANK_SPAN = 24'h00001F;

    typedef enum logic [1:0] {
        BANK_GLOBAL = 2'b00,
        BANK_LOCAL1 = 2'b01,
        BANK_LOCAL2 = 2'b10
    } bank_sel_t;

    typedef enum logic [1:0] {
        SW_IDLE  = 2'b00,
        SW_SAVE  = 2'b01,
        SW_LOAD  = 2'b10,
        SW_WAIT  = 2'b11
    } switch_state_t;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        logic             byte_op;
        logic             hi_byte;
    } reg_rd_t;

    typedef struct packed {
        logic              en;
        logic [IDX_W-1:0]  idx;
        logic              byte_op;
        logic              hi_byte;
        logic [DATA_W-1:0] data;
    } reg_wr_t;

    typedef struct packed {
        logic              rd_en;
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } mem_req_t;

    typedef struct packed {
        logic              status_wr;
        logic [1:0]        status_bank;
        logic              int_entry;
        logic [1:0]        int_bank;
        logic              int_return;
        logic [1:0]        return_bank;
        logic              trap_entry;
    } bank_event_t;
endpackage

/* File: tb/banked_gpr_register_file_tb_top.sv */
// self-checking bench for the banked register file
`timescale 1ns/1ps
`default_nettype none
module banked_gpr_register_file_tb_top;
    import gpr_bank_pkg::*;
    logic             mclk = 1'b0;
    logic             rst_n = 1'b0;
    reg_rd_t [2:0]    rd_port = '0;
    reg_wr_t [1:0]    wr_port = '0;
    bank_event_t      bank_event = '0;
    mem_req_t         full_req = '0;
    logic [23:0]      base_ptr = 24'h000040;
    logic             context_switch = 1'b0;
    logic [2:0][15:0] rd_data;
    logic [1:0]       bank_select;
    logic             busy, full_hit, full_rvalid, ram_rd_en, ram_wr_en;
    logic [15:0]      full_rdata, ram_wdata, ram_rdata;
    logic [23:0]      ram_addr;
    logic [15:0]      bk [3][16];
    logic [15:0]      q [$];
    logic [2:0]       rv = '0;
    int               cur = 0;
    int               num_errors = 0;
    int               n_tests = 0;
    gpr_bank_file dut (.mclk, .rst_n, .rd_port, .rd_data, .wr_port, .bank_event,
        .context_base_pointer(base_ptr), .context_switch, .bank_select, .busy,
        .full_req, .full_hit, .full_rvalid, .full_rdata, .ram_rd_en, .ram_wr_en,
        .ram_addr, .ram_wdata, .ram_rdata);
    gpr_ram_model ram (.mclk, .rd_en(ram_rd_en), .wr_en(ram_wr_en), .addr(ram_addr),
        .wdata(ram_wdata), .rdata(ram_rdata));
    always #4 mclk = ~mclk;
    task automatic check(input string nm, input logic [23:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk) rv <= {rd_port[2].en, rd_port[1].en, rd_port[0].en} & {3{~busy}};
    always @(negedge mclk) begin
        for (int i = 0; i < 3; i++) begin
            if (rv[i]) check("rd_data", rd_data[i], q.pop_front());
        end
        if (full_rvalid) check("full_rdata", full_rdata, q.pop_front());
    end
    task automatic idle;
        int k;
        k = 0;
        repeat (2) @(negedge mclk);
        while (busy !== 1'b0 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        check("busy", busy, 24'h000000);
        @(posedge mclk);
        for (int n = 0; n < 16; n++) bk[0][n] = {base_ptr[8:1] + 8'(n), 8'h3C};
    endtask
    task automatic rd(input int n, input logic by, hi);
        logic [15:0] v;
        v = bk[cur][n];
        rd_port[n % 3] <= '{1'b1, 4'(n), by, hi};
        q.push_back(!by ? v : hi ? {8'h00, v[15:8]} : {8'h00, v[7:0]});
        @(posedge mclk);
        rd_port <= '0;
        @(posedge mclk);
    endtask
    // byte data repeated in both halves, so either lane convention lands right
    task automatic wr(input int n, input logic by, hi, input logic [15:0] d);
        wr_port[n % 2] <= '{1'b1, 4'(n), by, hi, d};
        if (!by) bk[cur][n] = d;
        else if (hi) bk[cur][n][15:8] = d[7:0];
        else bk[cur][n][7:0] = d[7:0];
        @(posedge mclk);
        wr_port <= '0;
        @(posedge mclk);
    endtask
    task automatic fr(input int off, input logic h);
        full_req <= '{1'b1, 1'b0, base_ptr + 24'(off), 16'h0000};
        @(negedge mclk);
        check("full_hit", full_hit, 24'(h));
        if (h) q.push_back(bk[0][off / 2]);
        @(posedge mclk);
        full_req <= '0;
        @(posedge mclk);
    endtask
    task automatic ev(input logic [9:0] e, input int b);
        bank_event <= e;
        @(posedge mclk);
        bank_event <= '0;
        cur = b;
        @(negedge mclk);
        check("bank_select", bank_select, 24'(b));
        @(posedge mclk);
    endtask
    initial begin
        void'($urandom(93));
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        idle;
        repeat (8) wr($urandom % 16, 1'b0, 1'b0, 16'($urandom));
        wr(3, 1'b1, 1'b1, 16'hA7A7);
        for (int n = 0; n < 16; n++) rd(n, 1'b0, 1'b0);
        rd(3, 1'b1, 1'b1);
        rd(3, 1'b1, 1'b0);
        fr(10, 1'b1);
        fr(30, 1'b1);
        fr(11, 1'b0);
        fr(32, 1'b0);
        ev(10'h280, 1);
        wr(0, 1'b0, 1'b0, 16'h1111);
        fr(0, 1'b0);
        ev(10'h060, 2);
        wr(0, 1'b0, 1'b0, 16'h2222);
        ev(10'h00A, 1);
        rd(0, 1'b0, 1'b0);
        ev(10'h301, 0);
        rd(0, 1'b0, 1'b0);
        ev(10'h280, 1);
        ev(10'h380, 0);
        context_switch <= 1'b1;
        base_ptr <= 24'h000080;
        @(posedge mclk);
        context_switch <= 1'b0;
        for (int n = 0; n < 16; n++) q.push_back(bk[0][n]);
        idle;
        for (int n = 0; n < 16; n++) check("saved", ram.mem[8'h20 + n], q.pop_front());
        for (int n = 0; n < 16; n++) rd(n, 1'b0, 1'b0);
        fr(4, 1'b1);
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        complete_run;
    end
endmodule
`default_nettype wire

/* File: tb/gpr_bank_file_sva.sv */
// port assertions for the banked register file
`timescale 1ns/1ps
`default_nettype none
module gpr_bank_file_sva
    import gpr_bank_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire bank_event_t bank_event,
    input wire logic        context_switch,
    input wire logic [1:0]  bank_select,
    input wire logic        busy,
    input wire mem_req_t    full_req,
    input wire logic        full_hit,
    input wire logic        full_rvalid,
    input wire logic        ram_rd_en,
    input wire logic        ram_wr_en,
    input wire logic [23:0] ram_addr
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_trap_global: assert property (
        bank_event.trap_entry && !busy |=> bank_select == 2'h0)
        else $error("trap kept local bank");
    a_int_bank: assert property (
        bank_event.int_entry && !bank_event.trap_entry && bank_event.int_bank != 2'b11 && !busy
        |=> bank_select == $past(bank_event.int_bank)) else $error("interrupt bank not taken");
    a_status_bank: assert property (
        bank_event.status_wr && bank_event[6:0] == 7'h00 && !busy
        && bank_event.status_bank != 2'h3
        |=> bank_select == $past(bank_event.status_bank)) else $error("status bank not taken");
    a_bank_legal: assert property (bank_select != 2'b11)
        else $error("bank code unused");
    a_hit_global: assert property (full_hit |-> bank_select == 2'b00 && !full_req.addr[0])
        else $error("hit outside global bank");
    a_hit_answer: assert property (full_hit |=> full_rvalid)
        else $error("hit read not answered");
    a_ram_excl: assert property (!(ram_rd_en && ram_wr_en))
        else $error("save and load overlap");
    a_save_step: assert property (
        ram_wr_en && $past(ram_wr_en) |-> ram_addr == $past(ram_addr) + 24'h000002)
        else $error("save address not stepping by two");
    a_switch_start: assert property (context_switch && !busy |=> busy)
        else $error("switch did not raise busy");
    a_load_pulse: assert property (ram_rd_en |=> !ram_rd_en ##1 !ram_rd_en)
        else $error("load strobes too close");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:100] !busy)
        else $error("switch too long");
endmodule
bind gpr_bank_file gpr_bank_file_sva u_sva (.mclk, .rst_n, .bank_event, .context_switch,
    .bank_select, .busy, .full_req, .full_hit, .full_rvalid, .ram_rd_en, .ram_wr_en, .ram_addr);
`default_nettype wire

/* File: tb/gpr_ram_model.sv */
// data ram stand-in for the register file's save and load port
`timescale 1ns/1ps
`default_nettype none
module gpr_ram_model (
    input  wire logic        mclk,
    input  wire logic        rd_en,
    input  wire logic        wr_en,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wdata,
    output logic      [15:0] rdata
);
    logic [15:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = {i[7:0], 8'h3C};
        end
        rdata = 16'h0000;
    end
    // outside a read the bus toggles, so stale data never looks valid
    always @(posedge mclk) begin
        if (wr_en) mem[addr[8:1]] <= wdata;
        rdata <= rd_en ? mem[addr[8:1]] : ~rdata;
    end
endmodule
`default_nettype wire
